// ===== src/dlc_clock_divider_unit.v
`include "dlc_map.vh"

// ****************************************************************
// divided clock generator
// ****************************************************************
module dlc_clock_divider_unit (
  input  wire       core_clk,
  input  wire       arst,
  input  wire       src_rise,
  input  wire [1:0] ratio,
  input  wire       release_in,
  output wire       div_out,
  output wire       started
);
  reg       run_ff;
  reg [2:0] cnt_ff;
  reg       out_ff;
  reg       go_ff;
  reg [2:0] nxt_cnt;
  reg       nxt_out;
  reg [2:0] half;

  assign div_out = out_ff;
  assign started = go_ff;

  always @* begin
    case (ratio)
      `DLC_DRAT_2: half = 3'h0;
      `DLC_DRAT_4: half = 3'h1;
      `DLC_DRAT_8: half = 3'h3;
      default:     half = 3'h0;
    endcase
    nxt_cnt = cnt_ff;
    nxt_out = out_ff;
    if (run_ff && src_rise) begin
      if (cnt_ff >= half) begin
        nxt_cnt = 3'h0;
        nxt_out = ~out_ff;
      end else begin
        nxt_cnt = cnt_ff + 3'h1;
      end
    end
  end

  // reset clears the stage and forces outputs low at once
  always @(posedge core_clk or posedge arst) begin
    if (arst) begin
      run_ff <= 1'b0;
      cnt_ff <= 3'h0;
      out_ff <= 1'b0;
      go_ff  <= 1'b0;
    end else begin
      go_ff <= 1'b0;
      if (!run_ff) begin
        // start only on an input edge so phase is fixed
        if (release_in && src_rise) begin
          run_ff <= 1'b1;
          out_ff <= 1'b1;
          cnt_ff <= 3'h0;
          go_ff  <= 1'b1;
        end
      end else begin
        cnt_ff <= nxt_cnt;
        out_ff <= nxt_out;
      end
    end
  end
endmodule

// ===== src/dlc_duty.v
// ****************************************************************
// duty cycle corrector for one loop output
// ****************************************************************
module dlc_duty #(
  parameter PER_W = 8
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             dcc_en,
  input  wire             src,
  input  wire [PER_W-1:0] half_per,
  output wire             out
);
  reg             src_d_ff;
  reg             out_ff;
  reg [PER_W-1:0] cnt_ff;
  reg             nxt_out;
  reg [PER_W-1:0] nxt_cnt;

  assign out = out_ff;

  always @* begin
    nxt_out = out_ff;
    nxt_cnt = cnt_ff;
    if (!dcc_en) begin
      nxt_out = src;
    end else if (src && !src_d_ff) begin
      nxt_out = 1'b1;
      nxt_cnt = {{(PER_W-1){1'b0}}, 1'b1};
    end else if (out_ff) begin
      // high time forced to half the measured period
      if (cnt_ff >= half_per) begin
        nxt_out = 1'b0;
      end else begin
        nxt_cnt = cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
      end
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src_d_ff <= 1'b0;
      out_ff   <= 1'b0;
      cnt_ff   <= {PER_W{1'b0}};
    end else begin
      src_d_ff <= src;
      out_ff   <= nxt_out;
      cnt_ff   <= nxt_cnt;
    end
  end
endmodule

// ===== src/dlc_map.vh
`ifndef DLC_MAP_VH
`define DLC_MAP_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define DLC_A_CTRL    12'h000
`define DLC_A_TAPSEL  12'h004
`define DLC_A_STATUS  12'h008
`define DLC_A_ISTAT   12'h00c
`define DLC_A_IMASK   12'h010

// ****************************************************************
// control register fields
// ****************************************************************
`define DLC_C_HOLD    0
`define DLC_C_OPDCC   1
`define DLC_C_OSDCC   2
`define DLC_C_FINE    4:3
`define DLC_C_OSDIV   6:5
`define DLC_C_DRAT    8:7
`define DLC_C_DSRC    10:9
`define DLC_CTRL_W    11
`define DLC_CTRL_RST  11'h000
`define DLC_TAPSEL_RST 16'h0000

// ****************************************************************
// tap select and status fields
// ****************************************************************
`define DLC_T_OP      7:0
`define DLC_T_OS      15:8
`define DLC_S_LOCK    0
`define DLC_S_CODE    15:8
`define DLC_S_SLAVE   23:16

// ****************************************************************
// encodings
// ****************************************************************
`define DLC_FINE_NONE 2'h0
`define DLC_FINE_45   2'h1
`define DLC_FINE_22   2'h2
`define DLC_FINE_11   2'h3
`define DLC_OSDIV_1   2'h0
`define DLC_OSDIV_2   2'h1
`define DLC_OSDIV_4   2'h2
`define DLC_DRAT_2    2'h0
`define DLC_DRAT_4    2'h1
`define DLC_DRAT_8    2'h2
`define DLC_SRC_OP    2'h0
`define DLC_SRC_SLAVE 2'h1
`define DLC_SRC_ROUTE 2'h2
`define DLC_SRC_EXT   2'h3

// ****************************************************************
// interrupt events
// ****************************************************************
`define DLC_EV_W      3
`define DLC_EV_LOCK   0
`define DLC_EV_UNLOCK 1
`define DLC_EV_DIVGO  2
`define DLC_EV_RST    3'h0

`endif

// ===== src/dlc_top.v
// What this block does
// - code engine steps taps to align feedback
// - engine code driven onto slave delay bus
// - hold input freezes engine code
// - update input latches code bus value
// - each loop output picks its own tap
// - secondary fine shift 45, 22.5, 11.25
// - secondary optional divide by two, four
// - separate duty correction on both outputs
// - locked flag high while loop is locked
// - divider ratio two, four or eight
// - divider phase fixed at first input edge after release
// - divider reset forces outputs low asynchronously
// - release restarts divider on input edge
// - divider source selectable from four origins
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`include "dlc_map.vh"

module dlc_top #(
  parameter CODE_W = 6,
  parameter PER_W  = 8,
  parameter LOCK_N = 4
) (
  input  wire              core_clk,
  input  wire              rst,
  input  wire [11:0]       paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output wire [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              ref_clk_in,
  input  wire              feedback_clk_in,
  input  wire              routing_clk_in,
  input  wire              ext_clk_in,
  input  wire              code_hold,
  input  wire              control_code_update,
  input  wire              clock_divider_reset,
  input  wire              divider_release,
  output wire [CODE_W-1:0] delay_control_code,
  output wire [CODE_W-1:0] slave_code,
  output wire              primary_loop_clock,
  output wire              secondary_loop_clock,
  output wire              delay_locked,
  output wire              divided_clock,
  output wire              irq
);
  localparam TAPS = 1 << CODE_W;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function [CODE_W-1:0] sat_add;
    input [CODE_W-1:0] a;
    input [CODE_W-1:0] b;
    reg   [CODE_W:0]   s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[CODE_W] ? {CODE_W{1'b1}} : s[CODE_W-1:0];
    end
  endfunction

  function rise;
    input now;
    input was;
    begin
      rise = now & ~was;
    end
  endfunction

  // ****************************************************************
  // pin synchronisers: level rises when stages two and three agree high, falls when they differ
  // ****************************************************************
  reg [3:0] sy1_ff;
  reg [3:0] sy2_ff;
  reg [3:0] sy3_ff;
  reg [3:0] lvl_ff;
  reg [3:0] lvl_d_ff;
  wire [3:0] pins = {ext_clk_in, routing_clk_in, feedback_clk_in,
                     ref_clk_in};

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sy1_ff   <= 4'h0;
      sy2_ff   <= 4'h0;
      sy3_ff   <= 4'h0;
      lvl_ff   <= 4'h0;
      lvl_d_ff <= 4'h0;
    end else begin
      sy1_ff   <= pins;
      sy2_ff   <= sy1_ff;
      sy3_ff   <= sy2_ff;
      lvl_ff   <= (lvl_ff & ~(sy2_ff ^ sy3_ff)) |
                  (sy2_ff & (sy2_ff ~^ sy3_ff));
      lvl_d_ff <= lvl_ff;
    end
  end

  wire ref_lvl  = lvl_ff[0];
  wire ref_rise = rise(lvl_ff[0], lvl_d_ff[0]);
  wire fb_lvl   = lvl_ff[1];

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [`DLC_CTRL_W-1:0] ctrl_ff;
  reg [15:0]            tapsel_ff;
  reg [`DLC_EV_W-1:0]   istat_ff;
  reg [`DLC_EV_W-1:0]   imask_ff;
  reg [31:0]            prdata_ff;
  reg                   pready_ff;
  reg                   pslverr_ff;
  reg                   irq_ff;
  reg [31:0]            nxt_rdata;
  reg                   hit;

  wire acc = psel & penable & ~pready_ff;
  wire wr  = psel & penable & pready_ff & pwrite & ~pslverr_ff;

  // ****************************************************************
  // tapped delay line and code engine
  // ****************************************************************
  reg [TAPS-1:0]   line_ff;
  reg [CODE_W-1:0] code_ff;
  reg [CODE_W-1:0] slave_ff;
  reg              dir_ff;
  reg [3:0]        rev_ff;
  reg              lock_ff;
  reg [PER_W-1:0]  per_cnt_ff;
  reg [PER_W-1:0]  per_ff;
  reg [1:0]        osdiv_ff;
  reg              os_tap_d_ff;
  wire             hold = code_hold | ctrl_ff[`DLC_C_HOLD];
  wire             up   = fb_lvl;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      line_ff    <= {TAPS{1'b0}};
      code_ff    <= {CODE_W{1'b0}};
      slave_ff   <= {CODE_W{1'b0}};
      dir_ff     <= 1'b0;
      rev_ff     <= 4'h0;
      lock_ff    <= 1'b0;
      per_cnt_ff <= {PER_W{1'b0}};
      per_ff     <= {PER_W{1'b0}};
    end else begin
      line_ff <= {line_ff[TAPS-2:0], ref_lvl};
      if (control_code_update) begin
        slave_ff <= code_ff;
      end
      if (ref_rise) begin
        per_ff     <= per_cnt_ff;
        per_cnt_ff <= {{(PER_W-1){1'b0}}, 1'b1};
      end else if (per_cnt_ff != {PER_W{1'b1}}) begin
        per_cnt_ff <= per_cnt_ff + {{(PER_W-1){1'b0}}, 1'b1};
      end
      // feedback already high at reference edge: add delay
      if (ref_rise && !hold) begin
        if (up && code_ff != {CODE_W{1'b1}}) begin
          code_ff <= code_ff + {{(CODE_W-1){1'b0}}, 1'b1};
        end else if (!up && code_ff != {CODE_W{1'b0}}) begin
          code_ff <= code_ff - {{(CODE_W-1){1'b0}}, 1'b1};
        end
        dir_ff <= up;
        // dithering about one tap means the edges match
        if (up != dir_ff) begin
          if (rev_ff != LOCK_N[3:0]) begin
            rev_ff <= rev_ff + 4'h1;
          end else begin
            lock_ff <= 1'b1;
          end
        end else begin
          rev_ff  <= 4'h0;
          lock_ff <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // output tap selection, fine shift, divide
  // ****************************************************************
  reg [CODE_W-1:0] fine;
  always @* begin
    case (ctrl_ff[`DLC_C_FINE])
      `DLC_FINE_45: fine = code_ff >> 3;
      `DLC_FINE_22: fine = code_ff >> 4;
      `DLC_FINE_11: fine = code_ff >> 5;
      default:      fine = {CODE_W{1'b0}};
    endcase
  end

  wire [CODE_W-1:0] op_idx =
    sat_add(code_ff, tapsel_ff[CODE_W-1:0]);
  wire [CODE_W-1:0] os_idx =
    sat_add(sat_add(code_ff, tapsel_ff[CODE_W+7:8]), fine);
  wire op_tap    = line_ff[op_idx];
  wire os_tap    = line_ff[os_idx];
  wire slave_tap = line_ff[slave_ff];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      osdiv_ff    <= 2'h0;
      os_tap_d_ff <= 1'b0;
    end else begin
      os_tap_d_ff <= os_tap;
      if (rise(os_tap, os_tap_d_ff)) begin
        osdiv_ff <= osdiv_ff + 2'h1;
      end
    end
  end

  reg os_src;
  always @* begin
    case (ctrl_ff[`DLC_C_OSDIV])
      `DLC_OSDIV_2: os_src = osdiv_ff[0];
      `DLC_OSDIV_4: os_src = osdiv_ff[1];
      default:      os_src = os_tap;
    endcase
  end

  wire [PER_W-1:0] half_per = per_ff >> 1;
  wire             op_out;
  wire             os_out;

  dlc_duty #(.PER_W(PER_W)) u_op_duty (
    .core_clk (core_clk),
    .rst      (rst),
    .dcc_en   (ctrl_ff[`DLC_C_OPDCC]),
    .src      (op_tap),
    .half_per (half_per),
    .out      (op_out)
  );

  dlc_duty #(.PER_W(PER_W)) u_os_duty (
    .core_clk (core_clk),
    .rst      (rst),
    .dcc_en   (ctrl_ff[`DLC_C_OSDCC]),
    .src      (os_src),
    .half_per (half_per << (ctrl_ff[`DLC_C_OSDIV] &
                            {2{^ctrl_ff[`DLC_C_OSDIV]}})),
    .out      (os_out)
  );

  // ****************************************************************
  // clock divider
  // ****************************************************************
  reg div_src;
  reg div_src_d_ff;
  always @* begin
    case (ctrl_ff[`DLC_C_DSRC])
      `DLC_SRC_OP:    div_src = op_out;
      `DLC_SRC_SLAVE: div_src = slave_tap;
      `DLC_SRC_ROUTE: div_src = lvl_ff[2];
      `DLC_SRC_EXT:   div_src = lvl_ff[3];
      default:        div_src = op_out;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_src_d_ff <= 1'b0;
    end else begin
      div_src_d_ff <= div_src;
    end
  end

  wire div_arst = rst | clock_divider_reset;
  wire div_go;

  dlc_clock_divider_unit u_div (
    .core_clk   (core_clk),
    .arst       (div_arst),
    .src_rise   (rise(div_src, div_src_d_ff)),
    .ratio      (ctrl_ff[`DLC_C_DRAT]),
    .release_in (divider_release),
    .div_out    (divided_clock),
    .started    (div_go)
  );

  // ****************************************************************
  // apb slave and interrupts
  // ****************************************************************
  reg lock_d_ff;
  wire [`DLC_EV_W-1:0] ev = {div_go, lock_d_ff & ~lock_ff,
                             lock_ff & ~lock_d_ff};

  always @* begin
    nxt_rdata = 32'h0000_0000;
    hit       = 1'b1;
    case (paddr)
      `DLC_A_CTRL:   nxt_rdata[`DLC_CTRL_W-1:0] = ctrl_ff;
      `DLC_A_TAPSEL: nxt_rdata[15:0] = tapsel_ff;
      `DLC_A_STATUS: begin
        nxt_rdata[`DLC_S_LOCK] = lock_ff;
        nxt_rdata[`DLC_S_CODE] = {{(8-CODE_W){1'b0}}, code_ff};
        nxt_rdata[`DLC_S_SLAVE] = {{(8-CODE_W){1'b0}}, slave_ff};
      end
      `DLC_A_ISTAT:  nxt_rdata[`DLC_EV_W-1:0] = istat_ff;
      `DLC_A_IMASK:  nxt_rdata[`DLC_EV_W-1:0] = imask_ff;
      default:       hit = 1'b0;
    endcase
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff    <= `DLC_CTRL_RST;
      tapsel_ff  <= `DLC_TAPSEL_RST;
      istat_ff   <= `DLC_EV_RST;
      imask_ff   <= `DLC_EV_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff     <= 1'b0;
      lock_d_ff  <= 1'b0;
    end else begin
      lock_d_ff  <= lock_ff;
      pready_ff  <= acc;
      pslverr_ff <= acc & ~hit;
      if (acc) begin
        prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      end
      if (wr && paddr == `DLC_A_CTRL) begin
        ctrl_ff <= pwdata[`DLC_CTRL_W-1:0];
      end
      if (wr && paddr == `DLC_A_TAPSEL) begin
        tapsel_ff <= pwdata[15:0];
      end
      if (wr && paddr == `DLC_A_IMASK) begin
        imask_ff <= pwdata[`DLC_EV_W-1:0];
      end
      // a new event wins over a write-one clear
      if (wr && paddr == `DLC_A_ISTAT) begin
        istat_ff <= (istat_ff & ~pwdata[`DLC_EV_W-1:0]) | ev;
      end else begin
        istat_ff <= istat_ff | ev;
      end
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  assign prdata               = prdata_ff;
  assign pready               = pready_ff;
  assign pslverr              = pslverr_ff;
  assign delay_control_code   = code_ff;
  assign slave_code           = slave_ff;
  assign primary_loop_clock   = op_out;
  assign secondary_loop_clock = os_out;
  assign delay_locked         = lock_ff;
  assign irq                  = irq_ff;
endmodule

// ===== verification/delay_loop_and_clock_divider_tb.sv
`include "dlc_map.vh"

// ******************************
// testbench
// ******************************
module delay_loop_and_clock_divider_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic        code_hold = 1'b0, control_code_update = 1'b0;
  logic        clock_divider_reset = 1'b0, go = 1'b0, win = 1'b0;
  logic [10:0] ctrl = 11'h000;
  logic [31:0] lfsr_st = 32'h7ae8d21a;
  logic [64:0] exp_q[$];
  logic [1:0]  src_t[6] = '{`DLC_SRC_OP, `DLC_SRC_SLAVE, `DLC_SRC_ROUTE,
                            `DLC_SRC_EXT, `DLC_SRC_EXT, `DLC_SRC_EXT};
  logic [1:0]  rat_t[6] = '{`DLC_DRAT_2, `DLC_DRAT_4, `DLC_DRAT_8,
                            `DLC_DRAT_2, `DLC_DRAT_4, `DLC_DRAT_8};
  wire  [31:0] prdata;
  wire  [5:0]  delay_control_code, slave_code;
  wire         pready, pslverr, ref_clk_in, feedback_clk_in, irq;
  wire         routing_clk_in, ext_clk_in, divider_release;
  wire         primary_loop_clock, secondary_loop_clock;
  wire         delay_locked, divided_clock, src_pin;
  int          error_cnt = 0, comparisons = 0, cycles = 0, ratio;
  int          src_n, div_n, sec_n, pri_n, sec_div;

  always #5 core_clk = ~core_clk;

  dlc_top dut (
    .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
    .feedback_clk_in(feedback_clk_in), .routing_clk_in(routing_clk_in),
    .ext_clk_in(ext_clk_in), .code_hold(code_hold),
    .control_code_update(control_code_update),
    .clock_divider_reset(clock_divider_reset),
    .divider_release(divider_release),
    .delay_control_code(delay_control_code), .slave_code(slave_code),
    .primary_loop_clock(primary_loop_clock),
    .secondary_loop_clock(secondary_loop_clock),
    .delay_locked(delay_locked), .divided_clock(divided_clock), .irq(irq)
  );

  dlc_user u_user (
    .core_clk(core_clk), .rst(rst), .go(go), .loop_clk(primary_loop_clock),
    .ref_clk(ref_clk_in), .fb_clk(feedback_clk_in),
    .route_clk(routing_clk_in), .ext_clk(ext_clk_in),
    .release_out(divider_release)
  );

  // pin that feeds the divider, for edge counting
  assign src_pin = (ctrl[10:9] == `DLC_SRC_ROUTE) ? routing_clk_in :
                   (ctrl[10:9] == `DLC_SRC_EXT) ? ext_clk_in : ref_clk_in;
  always @(posedge src_pin) if (win) src_n++;
  always @(posedge divided_clock) if (win) div_n++;
  always @(posedge secondary_loop_clock) if (win) sec_n++;
  always @(posedge primary_loop_clock) if (win) pri_n++;

  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic err);
    exp_q.push_back({err, (wr ? 32'hffffffff : m), (wr ? 32'h0 : d)});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // answer side: oldest note against each completed access
  always @(posedge core_clk) begin
    logic [64:0] e;
    if (pready === 1'b1) begin
      e = exp_q.pop_front();
      chk({31'h0, pslverr}, {31'h0, e[64]});
      chk(prdata & e[63:32], e[31:0] & e[63:32]);
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      $display("wrong value at %0t: run did not finish", $time);
      conclude();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, `DLC_A_CTRL, 32'h0, '1, 1'b0);
    apb(1'b0, `DLC_A_TAPSEL, 32'h0, '1, 1'b0);
    apb(1'b0, `DLC_A_ISTAT, 32'h0, '1, 1'b0);
    apb(1'b0, `DLC_A_IMASK, 32'h0, '1, 1'b0);
    apb(1'b1, `DLC_A_STATUS, 32'h1, '1, 1'b0);
    apb(1'b0, `DLC_A_STATUS, 32'h0, 32'h1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      lfsr_st = nxt_rand(lfsr_st);
      apb(1'b1, `DLC_A_TAPSEL, lfsr_st, '1, 1'b0);
      apb(1'b0, `DLC_A_TAPSEL, {16'h0, lfsr_st[15:0]}, '1, 1'b0);
    end
    apb(1'b1, 12'h014, lfsr_st, '1, 1'b1);
    apb(1'b0, 12'h014, 32'h0, '1, 1'b1);
    // primary offset puts the feedback edge in the late half
    apb(1'b1, `DLC_A_TAPSEL, 32'h0e0e, '1, 1'b0);
    apb(1'b1, `DLC_A_IMASK, 32'h1, '1, 1'b0);
    while (delay_locked !== 1'b1) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b1);
    apb(1'b0, `DLC_A_ISTAT, 32'h1, 32'h1, 1'b0);
    apb(1'b1, `DLC_A_IMASK, 32'h4, '1, 1'b0);
    repeat (2) @(posedge core_clk);
    chk(irq, 1'b0);
    code_hold <= 1'b1;
    repeat (100) @(posedge core_clk);
    control_code_update <= 1'b1;
    @(posedge core_clk);
    control_code_update <= 1'b0;
    code_hold <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      ctrl = {src_t[i], rat_t[i], 2'(i % 3), 2'(i % 4), 2'(i % 4), 1'b0};
      apb(1'b1, `DLC_A_CTRL, {21'h0, ctrl}, '1, 1'b0);
      apb(1'b0, `DLC_A_CTRL, {21'h0, ctrl}, '1, 1'b0);
      while (i > 0 && divided_clock !== 1'b1) @(posedge core_clk);
      clock_divider_reset <= 1'b1;
      go <= 1'b0;
      #1 chk(divided_clock, 1'b0);
      repeat (2) @(posedge core_clk);
      clock_divider_reset <= 1'b0;
      go <= 1'b1;
      repeat (60) @(posedge core_clk);
      {src_n, div_n, sec_n, pri_n} = '0;
      win = 1'b1;
      repeat (800) @(posedge core_clk);
      win = 1'b0;
      ratio = 2 << rat_t[i];
      chk(div_n * ratio <= src_n + ratio + 1 &&
          div_n * ratio + ratio + 1 >= src_n, 1'b1);
      chk(sec_n > 0 && pri_n > 0, 1'b1);
      sec_div = 1 << (i % 3);
      chk(sec_n * sec_div <= pri_n + sec_div + 2 &&
          sec_n * sec_div + sec_div + 2 >= pri_n, 1'b1);
      apb(1'b0, `DLC_A_ISTAT, 32'h4, 32'h4, 1'b0);
      chk(irq, 1'b1);
      apb(1'b1, `DLC_A_ISTAT, 32'h4, '1, 1'b0);
      repeat (2) @(posedge core_clk);
      chk(irq, 1'b0);
    end
    conclude();
  end
endmodule

// ===== verification/dlc_chk.sv
// ******************************
// port checker
// ******************************
module dlc_chk #(
  parameter CODE_W = 6
) (
  input logic              core_clk,
  input logic              rst,
  input logic              psel,
  input logic              penable,
  input logic              pwrite,
  input logic [31:0]       prdata,
  input logic              pready,
  input logic              pslverr,
  input logic              code_hold,
  input logic              control_code_update,
  input logic              clock_divider_reset,
  input logic              divider_release,
  input logic [CODE_W-1:0] delay_control_code,
  input logic [CODE_W-1:0] slave_code,
  input logic              delay_locked,
  input logic              divided_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  step_size_a: assert property ($changed(delay_control_code) |->
    delay_control_code == $past(delay_control_code) + 1'b1 ||
    delay_control_code == $past(delay_control_code) - 1'b1)
    else $error("code moved by more than one step");
  hold_freeze_a: assert property (
    code_hold |=> $stable(delay_control_code))
    else $error("code moved while held");
  code_latch_a: assert property (
    control_code_update |=> slave_code == $past(delay_control_code))
    else $error("slave code not latched");
  div_reset_a: assert property (clock_divider_reset |-> !divided_clock)
    else $error("divided clock high in divider reset");
  release_gate_a: assert property (clock_divider_reset ##1
    (!clock_divider_reset && !divider_release) [*3] |-> !divided_clock)
    else $error("divider ran without release");

  cover property (pready && pslverr);
  cover property ($rose(delay_locked));
  cover property (control_code_update && code_hold);
  cover property ($rose(divided_clock));
endmodule

bind dlc_top dlc_chk #(.CODE_W(CODE_W)) u_chk (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .code_hold(code_hold), .control_code_update(control_code_update),
  .clock_divider_reset(clock_divider_reset),
  .divider_release(divider_release),
  .delay_control_code(delay_control_code), .slave_code(slave_code),
  .delay_locked(delay_locked), .divided_clock(divided_clock)
);

// ===== verification/dlc_user.sv
// ******************************
// user core logic at the pins
// ******************************
module dlc_user #(
  parameter SETTLE = 8
) (
  input  wire  core_clk,
  input  wire  rst,
  input  wire  go,
  input  wire  loop_clk,
  output logic ref_clk,
  output logic fb_clk,
  output logic route_clk,
  output logic ext_clk,
  output logic release_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int settle_cnt;

  initial begin
    ref_clk = 1'b0;
    route_clk = 1'b0;
    ext_clk = 1'b0;
  end
  // board clocks, unrelated in phase to core_clk
  always #103 ref_clk = ~ref_clk;
  always #67 route_clk = ~route_clk;
  always #41 ext_clk = ~ext_clk;
  // loop output returned as feedback
  assign fb_clk = loop_clk;

  // release only once the source has run a while
  always @(posedge core_clk or posedge rst) begin
    if (rst || !go) begin
      settle_cnt <= 0;
      release_out <= 1'b0;
    end else if (settle_cnt < SETTLE) begin
      settle_cnt <= settle_cnt + 1;
    end else begin
      release_out <= 1'b1;
    end
  end
endmodule
